// File: rtl/uie_pkg.sv
// package: register map, field positions, reset values and carriers for the interrupt enable block
package uie_pkg;

   // printed register indices; byte address is four times the index
   localparam logic [3:0] IDX_TRIGGER_LEVEL_SET = 4'h0, IDX_FIFO_COUNT_READ = 4'h0;
   localparam logic [3:0] IDX_FEATURE_CONTROL = 4'h1, IDX_ENHANCED_FUNCTION = 4'h2;
   localparam logic [3:0] IDX_RESUME_CHAR_1 = 4'h4, IDX_RESUME_CHAR_2 = 4'h5;
   localparam logic [3:0] IDX_PAUSE_CHAR_1 = 4'h6, IDX_PAUSE_CHAR_2 = 4'h7;
   localparam logic [3:0] IDX_INTERRUPT_ENABLE = 4'h8, IDX_FIFO_READY_SUMMARY = 4'h9;
   localparam logic [3:0] IDX_LINE_STATUS = 4'hA, IDX_INTERRUPT_STATUS = 4'hB;
   localparam logic [3:0] IDX_FIFO_CONTROL = 4'hC;

   localparam int ADDR_W = 6;

   // interrupt enable fields
   localparam int IE_RX_DATA = 0, IE_TX_READY = 1, IE_LINE = 2, IE_MODEM = 3;
   localparam int IE_SLEEP = 4, IE_PAUSE = 5, IE_RTS = 6, IE_CTS = 7;

   // enhanced function bit that unlocks the upper enable and tx trigger fields
   localparam int EF_UNLOCK = 4;
   // feature control fields
   localparam int FC_COUNT_RX = 7;
   localparam int FC_TABLE_LO = 4;
   // fifo control fields
   localparam int FCTL_ENABLE = 0;
   localparam int FCTL_TX_TRIG_LO = 4;
   localparam int FCTL_RX_TRIG_LO = 6;

   localparam logic [7:0] RESET_BYTE = 8'h00;

   // trigger tables A and B
   localparam logic [7:0] RX_TRIG_A0 = 8'h01;
   localparam logic [7:0] RX_TRIG_A1 = 8'h04;
   localparam logic [7:0] RX_TRIG_A2 = 8'h08;
   localparam logic [7:0] RX_TRIG_A3 = 8'h0E;
   localparam logic [7:0] RX_TRIG_B0 = 8'h08;
   localparam logic [7:0] RX_TRIG_B1 = 8'h10;
   localparam logic [7:0] RX_TRIG_B2 = 8'h18;
   localparam logic [7:0] RX_TRIG_B3 = 8'h1C;
   localparam logic [7:0] TX_TRIG_A = 8'h01;
   localparam logic [7:0] TX_TRIG_B0 = 8'h10;
   localparam logic [7:0] TX_TRIG_B1 = 8'h08;
   localparam logic [7:0] TX_TRIG_B2 = 8'h18;
   localparam logic [7:0] TX_TRIG_B3 = 8'h1E;

   // interrupt status source codes, bits 5:0
   localparam logic [5:0] ISR_LINE = 6'h06;
   localparam logic [5:0] ISR_RX_DATA = 6'h04;
   localparam logic [5:0] ISR_TX_READY = 6'h02;
   localparam logic [5:0] ISR_MODEM = 6'h00;
   localparam logic [5:0] ISR_PAUSE = 6'h10;
   localparam logic [5:0] ISR_FLOW_PIN = 6'h20;
   localparam logic [5:0] ISR_NONE = 6'h01;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] level;       // characters in the receive fifo or holding register
      logic char_loaded;       // pulse: character moved from shifter into fifo
      logic overrun;           // pulse: receive overrun
      logic [2:0] head_err;    // break, framing, parity of the head character
      logic fifo_err_any;      // some stored character carries an error
   } uie_rx_status_t;

   typedef struct packed {
      logic [7:0] level;       // characters in the transmit fifo
      logic holding_empty;     // transmit holding register empty
      logic all_empty;         // fifo and shift register both empty
      logic holding_write;     // pulse: host wrote the transmit holding register
   } uie_tx_status_t;

   typedef struct packed {
      logic modem_change;      // modem status delta bits pending
      logic modem_read;        // pulse: host read the modem status register
      logic pause_seen;        // pulse: pause character received
      logic resume_seen;       // pulse: resume character received
      logic rts_n;             // rts output pin level
      logic cts_n;             // cts input pin level
   } uie_flow_status_t;

endpackage

// File: rtl/uie_channel.sv
// one channel of interrupt enable, line status and enhanced registers behind an axi4-lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Contract
// - interrupt enable gates rx data, tx empty, line and modem sources into status.
// - fifo mode rx interrupt and status follow level at or above trigger.
// - data ready sets when a character enters the fifo, clears when empty.
// - clearing enables 0-3 with fifo on gives polled mode via line status.
// - line status bit 1 reports receive overrun.
// - line status bits 2-4 report errors of the head character.
// - bit 5 holding empty; bit 6 fifo and shifter both empty.
// - bit 7 set in fifo mode while any stored receive character has an error.
// - enable bit 0 rx interrupt: holding full, or fifo at trigger.
// - enable bit 1 tx interrupt: holding empties, or fifo below trigger.
// - enabling tx ready while already empty raises the interrupt at once.
// - enable bit 2 raises line interrupt when bits 1-4 set on reception.
// - enable bit 3 gates the modem status interrupt.
// - enable bit 4 is sleep enable, writable only with enhanced bit 4.
// - enable bit 5 gates pause character interrupt, writable only when unlocked.
// - enable bit 6 gates rts rising-edge interrupt, writable only when unlocked.
// - after reset all enables and sleep read zero.
// - enable bit 7 gates cts rising-edge interrupt, writable only when unlocked.
// - reading line status clears a pending line status interrupt.
module uie_channel (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [uie_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [uie_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire uie_pkg::uie_rx_status_t rx_status,
   input wire uie_pkg::uie_tx_status_t tx_status,
   input wire uie_pkg::uie_flow_status_t flow_status,
   input wire logic [2:0] peer_rx_ready_n,
   input wire logic [2:0] peer_tx_ready_n,
   output logic interrupt_request,
   output logic sleep_enable,
   output logic fifo_enable,
   output logic rx_ready_n,
   output logic tx_ready_n
);

   // registers; each instance owns its copy
   logic [7:0] interrupt_enable_reg, enhanced_function_reg, feature_control_reg;
   logic [7:0] trigger_level_set_reg, fifo_control_reg, resume_char_1_reg, resume_char_2_reg;
   logic [7:0] pause_char_1_reg, pause_char_2_reg;

   // pending event flags
   logic overrun_reg, line_pend_reg, tx_pend_reg, tx_cond_prev_reg, tx_en_prev_reg;
   logic pause_pend_reg, rts_pend_reg, cts_pend_reg, rts_prev_reg, cts_prev_reg;

   // axi state
   logic aw_held_reg, w_held_reg, w_lane0_reg, bvalid_reg, rvalid_reg;
   logic [3:0] aw_idx_reg;
   logic [7:0] w_byte_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;

   logic unlocked, do_write, wr_ok, rd_take, rd_line, rd_isr, rd_mapped, line_err_event;
   logic rx_data_ready, rx_cond, tx_cond;
   logic [3:0] rd_idx;
   logic [5:0] isr_code;
   logic [7:0] rx_trig, tx_trig, line_status, interrupt_status, rd_byte;
   logic [7:0] fifo_ready_summary, fifo_count_read;

   assign unlocked = enhanced_function_reg[uie_pkg::EF_UNLOCK];
   assign fifo_enable = fifo_control_reg[uie_pkg::FCTL_ENABLE];
   assign sleep_enable = interrupt_enable_reg[uie_pkg::IE_SLEEP];

   // ---------------- write channel: address and data taken in either order
   assign awready = !aw_held_reg && !bvalid_reg;
   assign wready = !w_held_reg && !bvalid_reg;
   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_ok = do_write && w_lane0_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg <= 4'h0;
      end else if (awvalid && awready) begin
         aw_held_reg <= 1'b1;
         aw_idx_reg <= awaddr[5:2];
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_byte_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
      end else if (wvalid && wready) begin
         w_held_reg <= 1'b1;
         w_byte_reg <= wdata[7:0];
         w_lane0_reg <= wstrb[0];
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= uie_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         unique case (aw_idx_reg)
            uie_pkg::IDX_TRIGGER_LEVEL_SET, uie_pkg::IDX_FEATURE_CONTROL,
            uie_pkg::IDX_ENHANCED_FUNCTION, uie_pkg::IDX_RESUME_CHAR_1,
            uie_pkg::IDX_RESUME_CHAR_2, uie_pkg::IDX_PAUSE_CHAR_1,
            uie_pkg::IDX_PAUSE_CHAR_2, uie_pkg::IDX_INTERRUPT_ENABLE,
            uie_pkg::IDX_FIFO_CONTROL: bresp_reg <= uie_pkg::RESP_OKAY;
            default: bresp_reg <= uie_pkg::RESP_SLVERR;
         endcase
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   // ---------------- register writes; upper enables need the unlock bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_enable_reg <= uie_pkg::RESET_BYTE;
      end else if (wr_ok && aw_idx_reg == uie_pkg::IDX_INTERRUPT_ENABLE) begin
         interrupt_enable_reg[3:0] <= w_byte_reg[3:0];
         if (unlocked) begin
            interrupt_enable_reg[7:4] <= w_byte_reg[7:4];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enhanced_function_reg <= uie_pkg::RESET_BYTE;
         feature_control_reg <= uie_pkg::RESET_BYTE;
         trigger_level_set_reg <= uie_pkg::RESET_BYTE;
         resume_char_1_reg <= uie_pkg::RESET_BYTE;
         resume_char_2_reg <= uie_pkg::RESET_BYTE;
         pause_char_1_reg <= uie_pkg::RESET_BYTE;
         pause_char_2_reg <= uie_pkg::RESET_BYTE;
      end else if (wr_ok) begin
         unique case (aw_idx_reg)
            uie_pkg::IDX_ENHANCED_FUNCTION: enhanced_function_reg <= w_byte_reg;
            uie_pkg::IDX_FEATURE_CONTROL: feature_control_reg <= w_byte_reg;
            uie_pkg::IDX_TRIGGER_LEVEL_SET: trigger_level_set_reg <= w_byte_reg;
            uie_pkg::IDX_RESUME_CHAR_1: resume_char_1_reg <= w_byte_reg;
            uie_pkg::IDX_RESUME_CHAR_2: resume_char_2_reg <= w_byte_reg;
            uie_pkg::IDX_PAUSE_CHAR_1: pause_char_1_reg <= w_byte_reg;
            uie_pkg::IDX_PAUSE_CHAR_2: pause_char_2_reg <= w_byte_reg;
            default: ;
         endcase
      end
   end

   // other fifo control fields only take effect when the enable bit is written as one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_control_reg <= uie_pkg::RESET_BYTE;
      end else if (wr_ok && aw_idx_reg == uie_pkg::IDX_FIFO_CONTROL) begin
         fifo_control_reg[uie_pkg::FCTL_ENABLE] <= w_byte_reg[0];
         if (w_byte_reg[0]) begin
            fifo_control_reg[7:6] <= w_byte_reg[7:6];
            if (unlocked) begin
               fifo_control_reg[5:4] <= w_byte_reg[5:4];
            end
         end
      end
   end

   // ---------------- trigger selection
   always_comb begin
      rx_trig = uie_pkg::RX_TRIG_A0;
      tx_trig = uie_pkg::TX_TRIG_A;
      unique case (feature_control_reg[5:4])
         2'h0: begin
            unique case (fifo_control_reg[7:6])
               2'h0: rx_trig = uie_pkg::RX_TRIG_A0;
               2'h1: rx_trig = uie_pkg::RX_TRIG_A1;
               2'h2: rx_trig = uie_pkg::RX_TRIG_A2;
               2'h3: rx_trig = uie_pkg::RX_TRIG_A3;
            endcase
         end
         2'h1: begin
            unique case (fifo_control_reg[7:6])
               2'h0: rx_trig = uie_pkg::RX_TRIG_B0;
               2'h1: rx_trig = uie_pkg::RX_TRIG_B1;
               2'h2: rx_trig = uie_pkg::RX_TRIG_B2;
               2'h3: rx_trig = uie_pkg::RX_TRIG_B3;
            endcase
            unique case (fifo_control_reg[5:4])
               2'h0: tx_trig = uie_pkg::TX_TRIG_B0;
               2'h1: tx_trig = uie_pkg::TX_TRIG_B1;
               2'h2: tx_trig = uie_pkg::TX_TRIG_B2;
               2'h3: tx_trig = uie_pkg::TX_TRIG_B3;
            endcase
         end
         default: begin
            // programmable tables use the written trigger level for both sides
            rx_trig = trigger_level_set_reg;
            tx_trig = trigger_level_set_reg;
         end
      endcase
   end

   // ---------------- receive and transmit conditions
   assign rx_data_ready = rx_status.level != 8'h00;
   // fifo mode compares against trigger, so the flag falls as soon as level drops below trigger
   assign rx_cond = fifo_enable ? (rx_status.level >= rx_trig) : rx_data_ready;
   assign tx_cond = fifo_enable ? (tx_status.level < tx_trig) : tx_status.holding_empty;

   // tx ready: set on the empty edge or on enabling while already empty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_pend_reg <= 1'b0;
         tx_cond_prev_reg <= 1'b0;
         tx_en_prev_reg <= 1'b0;
      end else begin
         tx_cond_prev_reg <= tx_cond;
         tx_en_prev_reg <= interrupt_enable_reg[uie_pkg::IE_TX_READY];
         if ((tx_cond && !tx_cond_prev_reg) ||
             (tx_cond && interrupt_enable_reg[uie_pkg::IE_TX_READY] && !tx_en_prev_reg)) begin
            tx_pend_reg <= 1'b1;
         end else if (rd_isr || tx_status.holding_write || !tx_cond) begin
            tx_pend_reg <= 1'b0;
         end
      end
   end

   // ---------------- line status errors; set wins over the clearing read
   assign line_err_event = rx_status.overrun ||
      (rx_status.char_loaded && rx_status.head_err != 3'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overrun_reg <= 1'b0;
      end else if (rx_status.overrun) begin
         overrun_reg <= 1'b1;
      end else if (rd_line) begin
         overrun_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_pend_reg <= 1'b0;
      end else if (line_err_event) begin
         line_pend_reg <= 1'b1;
      end else if (rd_line) begin
         line_pend_reg <= 1'b0;
      end
   end

   assign line_status = {rx_status.fifo_err_any & fifo_enable,
                         tx_status.all_empty, tx_status.holding_empty,
                         rx_status.head_err, overrun_reg, rx_data_ready};

   // ---------------- pause character and flow pin edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pause_pend_reg <= 1'b0;
      end else if (flow_status.pause_seen) begin
         pause_pend_reg <= 1'b1;
      end else if (rd_isr || flow_status.resume_seen) begin
         pause_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts_prev_reg <= 1'b1; // pins idle high
         cts_prev_reg <= 1'b1;
         rts_pend_reg <= 1'b0;
         cts_pend_reg <= 1'b0;
      end else begin
         rts_prev_reg <= flow_status.rts_n;
         cts_prev_reg <= flow_status.cts_n;
         if (flow_status.rts_n && !rts_prev_reg) begin
            rts_pend_reg <= 1'b1;
         end else if (flow_status.modem_read) begin
            rts_pend_reg <= 1'b0;
         end
         if (flow_status.cts_n && !cts_prev_reg) begin
            cts_pend_reg <= 1'b1;
         end else if (flow_status.modem_read) begin
            cts_pend_reg <= 1'b0;
         end
      end
   end

   // ---------------- prioritised status code
   always_comb begin
      isr_code = uie_pkg::ISR_NONE;
      if (interrupt_enable_reg[uie_pkg::IE_LINE] && line_pend_reg) begin
         isr_code = uie_pkg::ISR_LINE;
      end else if (interrupt_enable_reg[uie_pkg::IE_RX_DATA] && rx_cond) begin
         isr_code = uie_pkg::ISR_RX_DATA;
      end else if (interrupt_enable_reg[uie_pkg::IE_TX_READY] && tx_pend_reg) begin
         isr_code = uie_pkg::ISR_TX_READY;
      end else if (interrupt_enable_reg[uie_pkg::IE_MODEM] && flow_status.modem_change) begin
         isr_code = uie_pkg::ISR_MODEM;
      end else if (unlocked && interrupt_enable_reg[uie_pkg::IE_PAUSE] && pause_pend_reg) begin
         isr_code = uie_pkg::ISR_PAUSE;
      end else if (unlocked && ((interrupt_enable_reg[uie_pkg::IE_RTS] && rts_pend_reg) ||
                                (interrupt_enable_reg[uie_pkg::IE_CTS] && cts_pend_reg))) begin
         isr_code = uie_pkg::ISR_FLOW_PIN;
      end
   end

   assign interrupt_status = {fifo_enable, fifo_enable, isr_code};
   assign interrupt_request = !isr_code[0];

   // fifo ready pins: rx ready at or above trigger in fifo mode, else when data is there; tx ready below trigger in fifo mode, else when holding empty
   assign rx_ready_n = !rx_cond;
   assign tx_ready_n = !tx_cond;
   assign fifo_ready_summary = {peer_rx_ready_n, rx_ready_n, peer_tx_ready_n, tx_ready_n};
   assign fifo_count_read = feature_control_reg[uie_pkg::FC_COUNT_RX] ?
                            rx_status.level : tx_status.level;

   // ---------------- read channel: one cycle to answer
   assign arready = !rvalid_reg;
   assign rd_take = arvalid && arready;
   assign rd_idx = araddr[5:2];
   assign rd_line = rd_take && rd_idx == uie_pkg::IDX_LINE_STATUS;
   assign rd_isr = rd_take && rd_idx == uie_pkg::IDX_INTERRUPT_STATUS;

   always_comb begin
      rd_mapped = 1'b1;
      rd_byte = 8'h00;
      unique case (rd_idx)
         uie_pkg::IDX_FIFO_COUNT_READ: rd_byte = fifo_count_read;
         uie_pkg::IDX_FEATURE_CONTROL: rd_byte = feature_control_reg;
         uie_pkg::IDX_ENHANCED_FUNCTION: rd_byte = enhanced_function_reg;
         uie_pkg::IDX_RESUME_CHAR_1: rd_byte = resume_char_1_reg;
         uie_pkg::IDX_RESUME_CHAR_2: rd_byte = resume_char_2_reg;
         uie_pkg::IDX_PAUSE_CHAR_1: rd_byte = pause_char_1_reg;
         uie_pkg::IDX_PAUSE_CHAR_2: rd_byte = pause_char_2_reg;
         uie_pkg::IDX_INTERRUPT_ENABLE: rd_byte = interrupt_enable_reg;
         uie_pkg::IDX_FIFO_READY_SUMMARY: rd_byte = fifo_ready_summary;
         uie_pkg::IDX_LINE_STATUS: rd_byte = line_status;
         uie_pkg::IDX_INTERRUPT_STATUS: rd_byte = interrupt_status;
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= uie_pkg::RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_byte};
         rresp_reg <= rd_mapped ? uie_pkg::RESP_OKAY : uie_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

endmodule

// File: tb/uie_channel_properties.sv
// checker: reset state and status read-back properties of one channel
`timescale 1ns/1ps
module uie_channel_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [uie_pkg::ADDR_W-1:0] araddr,
   input wire logic [31:0] rdata,
   input wire uie_pkg::uie_rx_status_t rx_status,
   input wire uie_pkg::uie_tx_status_t tx_status,
   input wire logic interrupt_request,
   input wire logic sleep_enable,
   input wire logic fifo_enable
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire rd_ok = arvalid && arready;
   wire rd_lsr = rd_ok && araddr == {uie_pkg::IDX_LINE_STATUS, 2'b00};
   wire rd_isr = rd_ok && araddr == {uie_pkg::IDX_INTERRUPT_STATUS, 2'b00};
   property p_rst;
      disable iff (1'b0) !aresetn |=> !sleep_enable && !fifo_enable && !interrupt_request;
   endproperty
   a_rst: assert property (p_rst) else $error("state not idle after reset");
   property p_rdy; rd_lsr |=> rdata[0] == ($past(rx_status.level) != 8'h00); endproperty
   a_rdy: assert property (p_rdy) else $error("data ready bit wrong");
   property p_ovr; rx_status.overrun ##1 rd_lsr |=> rdata[1]; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun bit not reported");
   property p_err; rd_lsr |=> rdata[4:2] == $past(rx_status.head_err); endproperty
   a_err: assert property (p_err) else $error("error kind bits wrong");
   property p_tx;
      rd_lsr |=> rdata[6:5] == {$past(tx_status.all_empty), $past(tx_status.holding_empty)};
   endproperty
   a_tx: assert property (p_tx) else $error("transmit empty bits wrong");
   property p_glob;
      rd_lsr |=> rdata[7] == ($past(rx_status.fifo_err_any) && $past(fifo_enable));
   endproperty
   a_glob: assert property (p_glob) else $error("global error bit wrong");
   property p_none; rd_isr |=> rdata[0] == !$past(interrupt_request); endproperty
   a_none: assert property (p_none) else $error("status code disagrees with request");
   property p_fifo; rd_isr |=> rdata[7:6] == {2{$past(fifo_enable)}}; endproperty
   a_fifo: assert property (p_fifo) else $error("status fifo bits wrong");
   c_line: cover property (rx_status.overrun ##1 rd_lsr);
   c_isr: cover property (rd_isr ##1 !rdata[0]);
   c_irq: cover property ($rose(interrupt_request));
endmodule
bind uie_channel uie_channel_properties u_props (.aclk(aclk), .aresetn(aresetn),
   .arvalid(arvalid), .arready(arready), .araddr(araddr), .rdata(rdata),
   .rx_status(rx_status), .tx_status(tx_status), .interrupt_request(interrupt_request),
   .sleep_enable(sleep_enable), .fifo_enable(fifo_enable));

// File: tb/uie_host.sv
// host model: axi4-lite master running one register write or read at a time
`timescale 1ns/1ps
module uie_host (
   input wire logic aclk,
   output logic awvalid,
   input wire logic awready,
   output logic [uie_pkg::ADDR_W-1:0] addr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   output logic rdy,
   output logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   logic tmo;
   initial begin
      {awvalid, wvalid, rdy, arvalid, tmo} = 5'h00;
      addr = '0;
      wdata = '0;
   end
   // a ready seen 1 ns after an edge still stands at the next edge
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] v,
         output logic [7:0] d, output logic [1:0] rsp);
      logic a, w, r, done;
      int n;
      n = 0;
      done = 1'b0;
      @(posedge aclk);
      addr <= {idx, 2'b00};
      wdata <= {24'h000000, v};
      awvalid <= wr;
      wvalid <= wr;
      arvalid <= !wr;
      rdy <= 1'b1;
      while (!done && n < 40) begin
         #1;
         a = awvalid && awready;
         w = wvalid && wready;
         r = arvalid && arready;
         done = wr ? bvalid : rvalid;
         d = rdata[7:0];
         rsp = wr ? bresp : rresp;
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (r) arvalid <= 1'b0;
         n++;
      end
      rdy <= 1'b0;
      if (!done) tmo = 1'b1;
   endtask
endmodule

// File: tb/uie_channel_tb.sv
// self-checking bench for one channel: register access, status read-back, interrupt gating
`timescale 1ns/1ps
module uie_channel_tb;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, rdy, arvalid, arready, rvalid;
   logic irq, slp, fen;
   logic [5:0] addr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, rsp;
   logic [7:0] d, v;
   logic [3:0] regs [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
   uie_pkg::uie_rx_status_t rx;
   uie_pkg::uie_tx_status_t tx;
   uie_pkg::uie_flow_status_t fl;
   int failures, checks, seed, i;
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   uie_host u_host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .addr(addr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bresp(bresp),
      .rdy(rdy), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
      .rresp(rresp));
   uie_channel DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(addr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hF), .bvalid(bvalid), .bready(rdy), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(addr), .arprot(3'h0), .rvalid(rvalid), .rready(rdy),
      .rdata(rdata), .rresp(rresp), .rx_status(rx), .tx_status(tx), .flow_status(fl),
      .peer_rx_ready_n(3'h5), .peer_tx_ready_n(3'h2), .interrupt_request(irq),
      .sleep_enable(slp), .fifo_enable(fen), .rx_ready_n(), .tx_ready_n());
   function automatic logic [7:0] lsr_exp();
      return {rx.fifo_err_any, tx.all_empty, tx.holding_empty, rx.head_err, 1'b0, rx.level != 0};
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] val);
      u_host.xfer(wr, idx, val, d, rsp);
      if (u_host.tmo) begin
         failures++;
         summarize();
      end
   endtask
   task automatic rc(input logic [3:0] idx, input logic [7:0] e, input string nm);
      bus(1'b0, idx, 8'h00);
      chk(nm, e, d);
   endtask
   task automatic wait_irq(input logic e);
      repeat (2) @(posedge aclk);
      #1 chk("irq", {7'h00, e}, {7'h00, irq});
   endtask
   task automatic pulse_ovr();
      @(posedge aclk) rx.overrun <= 1'b1;
      @(posedge aclk) rx.overrun <= 1'b0;
   endtask
   task automatic summarize();
      if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      seed = 84362;
      failures = 0;
      checks = 0;
      aresetn = 1'b0;
      {rx, tx, fl} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rc(4'h8, 8'h00, "enable_reset");
      chk("sleep_reset", 8'h00, {7'h00, slp});
      for (i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         bus(1'b1, regs[i], v);
         rc(regs[i], v, "enhanced_reg");
         bus(1'b1, regs[i], 8'h00);
      end
      // write-only and read-only indices refuse the other direction
      for (i = 0; i < 2; i++) begin
         bus(i[0], i ? 4'h9 : 4'hC, 8'hFF);
         chk("refused_resp", {6'h00, uie_pkg::RESP_SLVERR}, {6'h00, rsp});
      end
      bus(1'b1, 4'h8, 8'hFF);
      rc(4'h8, 8'h0F, "enable_locked");
      bus(1'b1, 4'h2, 8'h10);
      bus(1'b1, 4'h8, 8'hF0);
      rc(4'h8, 8'hF0, "enable_open");
      chk("sleep", 8'h01, {7'h00, slp});
      @(posedge aclk) tx.holding_empty <= 1'b1;
      rc(4'hB, 8'h01, "isr_none");
      bus(1'b1, 4'h8, 8'h02);
      wait_irq(1'b1);
      rc(4'hB, 8'h02, "isr_tx");
      bus(1'b1, 4'hC, 8'h01);
      chk("fifo_on", 8'h01, {7'h00, fen});
      bus(1'b1, 4'h8, 8'h00);
      for (i = 0; i < 10; i++) begin
         @(posedge aclk) {rx.level, rx.head_err, rx.fifo_err_any, tx.holding_empty, tx.all_empty}
            <= (i < 2) ? {14{i[0]}} : 14'($random(seed));
         @(posedge aclk) rc(4'hA, lsr_exp(), "line_status");
         chk("polled_irq", 8'h00, {7'h00, irq});
      end
      @(posedge aclk) {rx, tx} <= '0;
      bus(1'b1, 4'h8, 8'h04);
      pulse_ovr();
      wait_irq(1'b1);
      rc(4'hB, 8'hC6, "isr_line");
      fork
         pulse_ovr();
         begin
            @(posedge aclk);
            rc(4'hA, 8'h02, "lsr_overrun");
         end
      join
      wait_irq(1'b0);
      bus(1'b1, 4'h8, 8'h01);
      bus(1'b1, 4'hC, 8'h81);
      for (i = 7; i < 10; i++) begin
         @(posedge aclk) rx.level <= (i == 8) ? 8'h08 : 8'h07;
         wait_irq(i == 8);
         if (i == 8) rc(4'hB, 8'hC4, "isr_rx");
      end
      rc(4'h9, 8'hB4, "ready_summary");
      @(posedge aclk) fl.modem_change <= 1'b1;
      for (i = 0; i < 2; i++) begin
         bus(1'b1, 4'h8, i ? 8'h08 : 8'h00);
         wait_irq(i[0]);
      end
      rc(4'hB, 8'hC0, "isr_modem");
      @(posedge aclk) fl.modem_change <= 1'b0;
      bus(1'b1, 4'h8, 8'h20);
      @(posedge aclk) fl.pause_seen <= 1'b1;
      @(posedge aclk) fl.pause_seen <= 1'b0;
      rc(4'hB, 8'hD0, "isr_pause");
      for (i = 0; i < 2; i++) begin
         bus(1'b1, 4'h8, i ? 8'h80 : 8'h40);
         @(posedge aclk) {fl.cts_n, fl.rts_n} <= i ? 2'b10 : 2'b01;
         wait_irq(1'b1);
         @(posedge aclk) fl.modem_read <= 1'b1;
         @(posedge aclk) {fl.modem_read, fl.cts_n, fl.rts_n} <= 3'h0;
         wait_irq(1'b0);
      end
      summarize();
   end
endmodule
